// ### common/mem_port_pkg.sv
// Shared constants, types and states of the memory data port
package mem_port_pkg;

	// ***************************************************************
	// Port geometry
	// ***************************************************************
	localparam int PORT_WIDTH_PARAM = 32;
	localparam int POINTER_WIDTH_PARAM = 32;
	localparam int LEN_WIDTH = 16;

	// Low address bits that carry no meaning for the configured width
	localparam int ALIGN_BITS = (PORT_WIDTH_PARAM == 32) ? 2 :
		(PORT_WIDTH_PARAM == 16) ? 1 : 0;

	// Address increment for one transferred word, in bytes
	localparam logic [POINTER_WIDTH_PARAM-1:0] POINTER_STEP =
		POINTER_WIDTH_PARAM'(PORT_WIDTH_PARAM / 8);

	// Mask of the address bits forced to zero by the alignment
	localparam logic [POINTER_WIDTH_PARAM-1:0] ALIGN_MASK =
		POINTER_WIDTH_PARAM'((1 << ALIGN_BITS) - 1);

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [POINTER_WIDTH_PARAM-1:0] POINTER_RESET = '0;
	localparam logic [PORT_WIDTH_PARAM-1:0] WORD_RESET = '0;
	localparam logic [LEN_WIDTH-1:0] LEN_RESET = '0;
	localparam logic [LEN_WIDTH-1:0] LEN_ONE = LEN_WIDTH'(1);
	localparam logic DIRECTION_RESET = 1'b1;

	// High selects a memory read, low a memory write
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef struct packed
	{
		logic rd;
		logic [POINTER_WIDTH_PARAM-1:0] addr;
		logic [LEN_WIDTH-1:0] len;
	} burst_cmd_s;

	typedef enum logic [1:0] {idle, reading, writing} port_state_e;

endpackage

// ### rtl/burst_addr_gen.sv
// Memory pointer generator: loads, aligns and advances per transfer
`timescale 1ns/10ps

module burst_addr_gen
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [mem_port_pkg::POINTER_WIDTH_PARAM-1:0] start_addr,
	input wire logic advance,
	output logic [mem_port_pkg::POINTER_WIDTH_PARAM-1:0] pointer
);
	import mem_port_pkg::*;

	// ***************************************************************
	// Pointer register
	// ***************************************************************
	logic [POINTER_WIDTH_PARAM-1:0] pointer_q;

	// Meaningless low bits are cleared at load, so the step keeps them clear
	always_ff @(posedge clk)
	begin
		if (!rstn)
			pointer_q <= POINTER_RESET;
		else if (load)
			pointer_q <= start_addr & ~ALIGN_MASK; // R12 R13 R14
		else if (advance)
			pointer_q <= pointer_q + POINTER_STEP; // R15
	end

	assign pointer = pointer_q;

	// ***************************************************************
	// Checks
	// ***************************************************************
	a_pointer_aligned: assert property (@(posedge clk) disable iff (!rstn)
		(pointer_q & ALIGN_MASK) == '0) // R12
		else $error("memory pointer not aligned to port width");

endmodule

// ### rtl/mem_data_port.sv
// Master data port that moves DMA bursts to and from shared memory
//
// Function
// R1: Request high whenever data must move.
// R2: Direction constant while request is high.
// R3: Direction high reads, low writes.
// R4: Word moves when request and acknowledge high.
// R5: Host acknowledges reads only with valid data.
// R6: Host holds read data stable during acknowledge.
// R7: Host acknowledge on write takes driven word.
// R8: Acknowledge may stall anytime; no loss.
// R9: End-of-burst output marks final burst word.
// R10: Write word driven at port width.
// R11: Memory pointer width is pointer width parameter.
// R12: 32-bit width: pointer bits below 2 unused.
// R13: 16-bit width: pointer bit 0 unused.
// R14: 8-bit width: every pointer bit used.
// R15: Pointer advances only after acknowledged transfers.
`timescale 1ns/10ps

module mem_data_port
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire mem_port_pkg::burst_cmd_s cmd,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [mem_port_pkg::PORT_WIDTH_PARAM-1:0] wr_data,
	output logic rd_valid,
	output logic [mem_port_pkg::PORT_WIDTH_PARAM-1:0] rd_data,
	output logic burst_done,
	output logic xfer_request,
	output logic xfer_direction,
	output logic burst_last,
	output logic [mem_port_pkg::PORT_WIDTH_PARAM-1:0] wr_word_out,
	output logic [mem_port_pkg::POINTER_WIDTH_PARAM-1:0] mem_pointer,
	input wire logic host_xfer_ack,
	input wire logic [mem_port_pkg::PORT_WIDTH_PARAM-1:0] rd_word_in
);
	import mem_port_pkg::*;

	// ***************************************************************
	// Declarations
	// ***************************************************************
	port_state_e state_q;
	port_state_e state_d;
	logic dir_q;
	logic [LEN_WIDTH-1:0] left_q;
	logic [LEN_WIDTH-1:0] load_left_q;
	logic wr_full_q;
	logic [PORT_WIDTH_PARAM-1:0] wr_word_q;
	logic [PORT_WIDTH_PARAM-1:0] rd_data_q;
	logic rd_valid_q;
	logic done_q;
	logic cmd_take;
	logic wr_take;
	logic xfer;
	logic final_xfer;

	// ***************************************************************
	// Handshake terms
	// ***************************************************************
	assign cmd_ready = (state_q == idle);
	assign cmd_take = cmd_valid && cmd_ready;

	// A write only asks for the bus once a word sits in the output register,
	// so the host never samples stale data; reads ask for the whole burst
	always_comb
	begin
		case (state_q)
			reading: xfer_request = 1'b1; // R1
			writing: xfer_request = wr_full_q; // R1
			default: xfer_request = 1'b0;
		endcase
	end

	assign xfer = xfer_request && host_xfer_ack; // R4
	assign final_xfer = xfer && (left_q == LEN_ONE);
	assign burst_last = xfer_request && (left_q == LEN_ONE); // R9

	// Refill in the same cycle as a transfer keeps writes back to back
	assign wr_ready = (state_q == writing) && (load_left_q != LEN_RESET)
		&& (!wr_full_q || xfer);
	assign wr_take = wr_valid && wr_ready;

	// ***************************************************************
	// Burst sequencing
	// ***************************************************************
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			idle:
			begin
				if (cmd_take && cmd.len != LEN_RESET)
					state_d = cmd.rd ? reading : writing; // R3
			end
			reading, writing:
			begin
				if (final_xfer)
					state_d = idle;
			end
			default: state_d = idle;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			state_q <= idle;
		else
			state_q <= state_d;
	end

	// Direction only changes while idle, so it stays put under a request
	always_ff @(posedge clk)
	begin
		if (!rstn)
			dir_q <= DIRECTION_RESET;
		else if (cmd_take)
			dir_q <= cmd.rd ? DIR_READ : DIR_WRITE; // R2 R3
	end

	assign xfer_direction = dir_q;

	// Words still to cross the port; a stall simply holds the count
	always_ff @(posedge clk)
	begin
		if (!rstn)
			left_q <= LEN_RESET;
		else if (cmd_take)
			left_q <= cmd.len;
		else if (xfer)
			left_q <= left_q - LEN_ONE; // R4 R8
	end

	// Zero-length commands finish at once with no bus activity
	always_ff @(posedge clk)
	begin
		if (!rstn)
			done_q <= 1'b0;
		else
			done_q <= final_xfer || (cmd_take && cmd.len == LEN_RESET);
	end

	assign burst_done = done_q;

	// ***************************************************************
	// Write data path
	// ***************************************************************
	always_ff @(posedge clk)
	begin
		if (!rstn)
			load_left_q <= LEN_RESET;
		else if (cmd_take && !cmd.rd)
			load_left_q <= cmd.len;
		else if (wr_take)
			load_left_q <= load_left_q - LEN_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			wr_full_q <= 1'b0;
		else if (wr_take)
			wr_full_q <= 1'b1;
		else if (xfer && dir_q == DIR_WRITE)
			wr_full_q <= 1'b0;
	end

	// The word stays on the port until the host takes it
	always_ff @(posedge clk)
	begin
		if (!rstn)
			wr_word_q <= WORD_RESET;
		else if (wr_take)
			wr_word_q <= wr_data; // R10 R8
	end

	assign wr_word_out = wr_word_q;

	// ***************************************************************
	// Read data path
	// ***************************************************************
	// No read buffering: the consumer must accept every rd_valid pulse
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rd_data_q <= WORD_RESET;
		else if (xfer && dir_q == DIR_READ)
			rd_data_q <= rd_word_in; // R4 R5
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			rd_valid_q <= 1'b0;
		else
			rd_valid_q <= xfer && (dir_q == DIR_READ);
	end

	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;

	// ***************************************************************
	// Memory pointer
	// ***************************************************************
	burst_addr_gen u_addr
	(
		.clk(clk),
		.rstn(rstn),
		.load(cmd_take),
		.start_addr(cmd.addr),
		.advance(xfer), // R15
		.pointer(mem_pointer) // R11
	);

	// ***************************************************************
	// Checks
	// ***************************************************************
	a_dir_stable: assert property (@(posedge clk) disable iff (!rstn) // R2
		xfer_request && $past(xfer_request) |-> $stable(xfer_direction))
		else $error("direction changed under an active request");

	a_req_busy: assert property (@(posedge clk) disable iff (!rstn) // R1
		(state_q == reading) |-> xfer_request)
		else $error("read burst pending without a request");

	a_dir_code: assert property (@(posedge clk) disable iff (!rstn) // R3
		xfer_request |-> (xfer_direction == (state_q == reading)))
		else $error("direction level does not match transfer type");

	a_count_step: assert property (@(posedge clk) disable iff (!rstn) // R4
		xfer && !final_xfer |=> left_q == $past(left_q) - LEN_ONE)
		else $error("word count not decremented on transfer");

	a_stall_hold: assert property (@(posedge clk) disable iff (!rstn) // R8
		xfer_request && !host_xfer_ack |=>
		xfer_request && $stable(mem_pointer) && $stable(left_q)
		&& $stable(wr_word_out))
		else $error("port state moved during a stall");

	a_last_flag: assert property (@(posedge clk) disable iff (!rstn) // R9
		burst_last && host_xfer_ack |=> !xfer_request && burst_done)
		else $error("request still high or no done after end of burst");

	a_rd_capture: assert property (@(posedge clk) disable iff (!rstn) // R4
		xfer && xfer_direction |=> rd_valid && rd_data == $past(rd_word_in))
		else $error("read word not captured on transfer");

	a_wr_hold: assert property (@(posedge clk) disable iff (!rstn) // R10
		xfer_request && !xfer_direction && !host_xfer_ack |=>
		wr_word_out == $past(wr_word_out))
		else $error("write word changed before acknowledge");

	a_addr_step: assert property (@(posedge clk) disable iff (!rstn) // R15
		xfer && !final_xfer |=> mem_pointer == $past(mem_pointer) + POINTER_STEP)
		else $error("pointer did not advance by one word");

	a_addr_idle: assert property (@(posedge clk) disable iff (!rstn) // R15
		!xfer && !cmd_take |=> $stable(mem_pointer))
		else $error("pointer moved without a transfer");

	// Idle must look quiet on the port, even with a stale count left behind
	a_req_idle: assert property (@(posedge clk) disable iff (!rstn) // R1
		(state_q == idle) |-> !xfer_request && !burst_last)
		else $error("request raised while idle");

	a_write_dir: assert property (@(posedge clk) disable iff (!rstn) // R3
		(state_q == writing) |-> !xfer_direction)
		else $error("write burst not flagged as write");

	a_dir_idle_hold: assert property (@(posedge clk) disable iff (!rstn) // R2
		!cmd_take |=> $stable(xfer_direction))
		else $error("direction moved without a new command");

	a_wr_word_load: assert property (@(posedge clk) disable iff (!rstn) // R10
		wr_take |=> xfer_request && !xfer_direction && wr_word_out == $past(wr_data))
		else $error("loaded write word not offered to the host");

	a_wr_ready_gate: assert property (@(posedge clk) disable iff (!rstn) // R10
		wr_ready |-> (state_q == writing) && !xfer_direction)
		else $error("write word accepted outside a write burst");

	a_rd_none: assert property (@(posedge clk) disable iff (!rstn) // R4
		!(xfer && xfer_direction) |=> !rd_valid)
		else $error("read word reported without a transfer");

	a_last_req: assert property (@(posedge clk) disable iff (!rstn) // R9
		burst_last |-> xfer_request)
		else $error("end of burst flagged without a request");

	a_last_once: assert property (@(posedge clk) disable iff (!rstn) // R9
		burst_last && host_xfer_ack |=> !burst_last)
		else $error("end of burst flagged twice");

	// A misaligned start is trimmed, never rejected
	a_ptr_load: assert property (@(posedge clk) disable iff (!rstn) // R11 R12
		cmd_take |=> mem_pointer == ($past(cmd.addr) & ~ALIGN_MASK))
		else $error("pointer not loaded from the aligned start");

endmodule

// ### tb/host_mem_model.sv
// Host memory model answering the device's memory data port
`timescale 1ns/10ps

module host_mem_model
	import mem_port_pkg::*;
(
	input wire logic clk,
	input wire logic go,
	input wire logic xfer_request,
	input wire logic xfer_direction,
	input wire logic [31:0] mem_pointer,
	input wire logic [31:0] wr_word_out,
	output logic host_xfer_ack,
	output logic [31:0] rd_word_in
);
	logic [31:0] mem [256];
	logic [7:0] idx;

	assign idx = mem_pointer[9:2];
	// Ack follows the bench's random stall bit, so it may drop mid-burst
	assign host_xfer_ack = go;
	// Data valid and steady only under ack; inverted junk otherwise
	assign rd_word_in = host_xfer_ack ? mem[idx] : ~mem[idx];

	always_ff @(posedge clk)
	begin
		if (xfer_request && host_xfer_ack && !xfer_direction)
		begin
			mem[idx] <= wr_word_out;
		end
	end
endmodule

// ### tb/mem_data_port_test.sv
// Self-checking bench for the memory data port
`timescale 1ns/10ps

module mem_data_port_test;
	import mem_port_pkg::*;
	logic clk = 0, rstn = 0, cmd_valid = 0, wr_valid = 0, go = 0, exp_rd = 0, exp_rv = 0;
	burst_cmd_s cmd = '0;
	logic [31:0] wr_data = '0, rd_data, wr_word_out, mem_pointer, rd_word_in, exp_ptr;
	logic cmd_ready, wr_ready, rd_valid, burst_done, xfer_request, xfer_direction;
	logic burst_last, host_xfer_ack;
	logic [31:0] lf = 32'h1236, img [256], rq [$], wq [$];
	int errors = 0, comparisons = 0, left = 0, cnt = 0;

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] align(input logic [31:0] a);
		return {a[31:2], 2'b00};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic burst(input logic rd, input logic [31:0] addr, input int len);
		int n;
		logic [7:0] b8;
		b8 = addr[9:2];
		@(posedge clk);
		cmd <= '{rd: rd, addr: addr, len: LEN_WIDTH'(len)};
		cmd_valid <= 1'b1;
		exp_rd = rd;
		exp_ptr = align(addr);
		left = len;
		cnt = 0;
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (int k = 0; k < len && !rd; k++)
		begin
			wr_data <= lf;
			wr_valid <= 1'b1;
			wq.push_back(lf);
			img[b8 + 8'(k)] = lf;
			n = 0;
			do
				@(negedge clk);
			while (wr_ready !== 1'b1 && ++n < 100);
			@(posedge clk);
		end
		wr_valid <= 1'b0;
		n = 0;
		do
			@(negedge clk);
		while (burst_done !== 1'b1 && ++n < 300);
		check(burst_done, 1'b1);
		check(cmd_ready, 1'b1);
		check(cnt, len);
	endtask

	// ***************************************************************
	// Clock, stalls and port monitor
	// ***************************************************************
	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		lf <= lfsr(lf);
		go <= lf[0] | lf[3];
	end

	always @(negedge clk)
	begin
		check(rd_valid, exp_rv);
		if (rd_valid)
			check(rd_data, rq.pop_front());
		exp_rv = xfer_request && host_xfer_ack && exp_rd;
		if (xfer_request)
			check(xfer_direction, exp_rd);
		if (xfer_request && host_xfer_ack)
		begin
			check(mem_pointer, exp_ptr);
			check(burst_last, left == 1);
			if (exp_rd)
				rq.push_back(img[exp_ptr[9:2]]);
			else
				check(wr_word_out, wq.pop_front());
			exp_ptr = exp_ptr + 32'h4;
			left--;
			cnt++;
		end
	end

	mem_data_port DUT (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .burst_done(burst_done),
		.xfer_request(xfer_request), .xfer_direction(xfer_direction),
		.burst_last(burst_last), .wr_word_out(wr_word_out), .mem_pointer(mem_pointer),
		.host_xfer_ack(host_xfer_ack), .rd_word_in(rd_word_in));

	host_mem_model mdl (.clk(clk), .go(go), .xfer_request(xfer_request),
		.xfer_direction(xfer_direction), .mem_pointer(mem_pointer),
		.wr_word_out(wr_word_out), .host_xfer_ack(host_xfer_ack), .rd_word_in(rd_word_in));

	// ***************************************************************
	// Sequence
	// ***************************************************************
	initial
	begin
		logic [31:0] a;
		int l;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check(xfer_request, 0);
		check(mem_pointer, POINTER_RESET);
		check(cmd_ready, 1'b1);
		check(burst_last, 1'b0);
		check(xfer_direction, DIRECTION_RESET);
		check(wr_word_out, WORD_RESET);
		// Release on a rising edge so the fifth edge still sees reset
		@(posedge clk);
		rstn <= 1'b1;
		burst(1'b0, 32'h103, 0);
		burst(1'b0, 32'h3FF, 1);
		burst(1'b1, 32'h3FD, 1);
		for (int i = 0; i < 12; i++)
		begin
			a = lf & 32'h1FF;
			// The read-back must cover only words that this pass wrote
			l = int'(lf[20:17]) + 1;
			burst(1'b0, a, l);
			burst(1'b1, a, l);
		end
		close_out;
	end

	// Budget covers all bursts with heavy stalling
	initial
	begin
		#(25 * 30000);
		errors++;
		close_out;
	end
endmodule
